// [rtl/serial_flash_write_control.sv]
`timescale 1ns/1ps
// Summary of operation
// - full erase opcode C7h or 60h erases the array, only with the latch set.
// - full erase is opcode alone and starts only when chip select rises cleanly.
// - opcode 06h sets the write allow latch.
// - after reset the write allow latch is cleared.
// - every write type command needs the latch set beforehand.
// - the latch clears by itself when a write operation finishes.
// - opcode 04h clears the latch and blocks write commands.
// - while busy only the status read opcode 05h and, during a pausable operation, pause B0h or 75h are served.
// - status write 01h plus one byte stores protect, quad allow and lock bits.
// - function read 48h returns the function byte with pause flags.
// - function write 42h updates reset enable, top bottom and four row locks.
// - opcode 35h switches all later frames to four wire command mode.
// - opcode F5h sent as two nibbles returns the device to serial mode.
// - B0h pauses sector erase, block erase or page program; 30h continues it.
// - program paused shows in function bit 2, erase paused in bit 3.
// - after a pause the device is ready within the pause latency.
// - a pause clears the latch; while paused only reads, continue and quad exit F5h work.
// - pausing an erase sets the erase paused flag; busy until settled.
// - pausing a program sets the program paused flag; busy until settled.
// - continue resumes the operation with its remaining time and clears the matching paused flag.
// - in four wire mode each byte is two nibbles, upper first.
// - busy time before and after a pause adds up to the full time.
// - busy flag reads one while an operation runs, zero when done.
module serial_flash_write_control #(
    parameter int PAUSE_CYC = flash_ctl_pkg::PAUSE_LATENCY_CYC,
    parameter int FULL_ERASE_CYC = 100000,
    parameter int SECTOR_ERASE_CYC = 20000,
    parameter int BLOCK_ERASE_CYC = 50000,
    parameter int PAGE_PROGRAM_CYC = 8000,
    parameter int STATUS_WRITE_CYC = 5000
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // serial pins
    input wire logic chipSelN,
    input wire logic serialClock,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOe,
    // internal state
    output flash_ctl_pkg::status_t statusOut,
    output flash_ctl_pkg::function_t functionOut,
    output logic quadModeOut,
    output flash_ctl_pkg::op_kind_t opKindOut,
    output logic opDoneOut
);
    ////////////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (PAUSE_CYC < 1 || FULL_ERASE_CYC < 1 || SECTOR_ERASE_CYC < 1 ||
        BLOCK_ERASE_CYC < 1 || PAGE_PROGRAM_CYC < 1 || STATUS_WRITE_CYC < 1) begin : badParams
        $error("all cycle counts must be at least one");
    end
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_PAUSING, SEQ_PAUSED} seq_state_t;
    function automatic logic isEither(input logic [7:0] op, input logic [7:0] a,
                                      input logic [7:0] b);
        isEither = (op == a) || (op == b);
    endfunction : isEither
    function automatic logic [31:0] durationOf(input flash_ctl_pkg::op_kind_t kind);
        unique case (kind)
            flash_ctl_pkg::KIND_FULL_ERASE: durationOf = 32'(FULL_ERASE_CYC);
            flash_ctl_pkg::KIND_SECTOR_ERASE: durationOf = 32'(SECTOR_ERASE_CYC);
            flash_ctl_pkg::KIND_BLOCK_ERASE: durationOf = 32'(BLOCK_ERASE_CYC);
            flash_ctl_pkg::KIND_PAGE_PROGRAM: durationOf = 32'(PAGE_PROGRAM_CYC);
            flash_ctl_pkg::KIND_STATUS_WRITE: durationOf = 32'(STATUS_WRITE_CYC);
            default: durationOf = flash_ctl_pkg::TIMER_LAST;
        endcase
    endfunction : durationOf
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic csMeta_r, csSync_r, csPrev_r;
    logic sclkMeta_r, sclkSync_r, sclkPrev_r;
    logic [3:0] ioMeta_r, ioSync_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            csMeta_r <= 1'b1;
            csSync_r <= 1'b1;
            csPrev_r <= 1'b1;
            sclkMeta_r <= 1'b0;
            sclkSync_r <= 1'b0;
            sclkPrev_r <= 1'b0;
            ioMeta_r <= 4'h0;
            ioSync_r <= 4'h0;
        end else begin
            csMeta_r <= chipSelN;
            csSync_r <= csMeta_r;
            csPrev_r <= csSync_r;
            sclkMeta_r <= serialClock;
            sclkSync_r <= sclkMeta_r;
            sclkPrev_r <= sclkSync_r;
            ioMeta_r <= ioIn;
            ioSync_r <= ioMeta_r;
        end
    end
    wire frameOn = ~csSync_r;
    wire frameEnd = csSync_r & ~csPrev_r;
    wire sclkRise = frameOn & sclkSync_r & ~sclkPrev_r;
    wire sclkFall = frameOn & ~sclkSync_r & sclkPrev_r;
    ////////////////////////////////////////////////////////////////////////////////
    // state registers
    seq_state_t state_r, state_nxt;
    flash_ctl_pkg::op_kind_t kind_r, kind_nxt;
    logic [31:0] remain_r, remain_nxt;
    logic [31:0] settle_r, settle_nxt;
    flash_ctl_pkg::status_t status_r, status_nxt;
    flash_ctl_pkg::function_t function_r, function_nxt;
    flash_ctl_pkg::frame_t frame_r, frame_nxt;
    logic quad_r, quad_nxt;
    logic done_r, done_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [3:0] txBits_r, txBits_nxt;
    logic txOn_r, txOn_nxt;
    logic [3:0] ioOut_r, ioOut_nxt;
    logic [3:0] ioOe_r, ioOe_nxt;
    ////////////////////////////////////////////////////////////////////////////////
    // frame receive
    wire [3:0] rxStep = quad_r ? flash_ctl_pkg::QUAD_STEP : flash_ctl_pkg::SERIAL_STEP;
    // serial msb first, quad upper nibble first
    wire [7:0] rxShift = quad_r ? {frame_r.shift[3:0], ioSync_r} :
                                  {frame_r.shift[6:0], ioSync_r[0]};
    wire [3:0] rxBitsSum = frame_r.bits + rxStep;
    wire byteDone = sclkRise && (rxBitsSum == flash_ctl_pkg::BITS_PER_BYTE);
    wire opcodeDone = byteDone && (frame_r.bytes == flash_ctl_pkg::BYTES_NONE);
    wire dataDone = byteDone && (frame_r.bytes == flash_ctl_pkg::BYTES_OPCODE);
    ////////////////////////////////////////////////////////////////////////////////
    // command decode at frame end; read opcodes 05h and 48h decode when the opcode byte completes
    wire [7:0] op = frame_r.opcode;
    wire aligned = (frame_r.bits == flash_ctl_pkg::BITS_NONE);
    wire opOnly = frameEnd && aligned && (frame_r.bytes == flash_ctl_pkg::BYTES_OPCODE);
    wire withData = frameEnd && aligned && (frame_r.bytes == flash_ctl_pkg::BYTES_WITH_DATA);
    wire addressed = frameEnd && aligned && (frame_r.bytes == flash_ctl_pkg::BYTES_ADDRESSED);
    wire isIdle = (state_r == SEQ_IDLE);
    wire isRun = (state_r == SEQ_RUN);
    wire isPaused = (state_r == SEQ_PAUSED);
    wire latch = status_r.writeAllowLatch;
    wire pausable = kind_r inside {flash_ctl_pkg::KIND_SECTOR_ERASE,
        flash_ctl_pkg::KIND_BLOCK_ERASE, flash_ctl_pkg::KIND_PAGE_PROGRAM};
    wire kindIsProgram = (kind_r == flash_ctl_pkg::KIND_PAGE_PROGRAM);
    wire doLatchSet = opOnly && isIdle && (op == flash_ctl_pkg::OP_LATCH_SET);
    wire doLatchClear = opOnly && isIdle && (op == flash_ctl_pkg::OP_LATCH_CLEAR);
    wire doFullErase = opOnly && isIdle && latch &&
        isEither(op, flash_ctl_pkg::OP_FULL_ERASE_A, flash_ctl_pkg::OP_FULL_ERASE_B);
    wire doSectorErase = addressed && isIdle && latch &&
        isEither(op, flash_ctl_pkg::OP_SECTOR_ERASE_A, flash_ctl_pkg::OP_SECTOR_ERASE_B);
    wire doBlockErase = addressed && isIdle && latch &&
        isEither(op, flash_ctl_pkg::OP_BLOCK_ERASE_A, flash_ctl_pkg::OP_BLOCK_ERASE_B);
    wire doPageProgram = addressed && isIdle && latch &&
        (op == flash_ctl_pkg::OP_PAGE_PROGRAM);
    wire doStatusWrite = withData && isIdle && latch &&
        (op == flash_ctl_pkg::OP_STATUS_WRITE);
    wire doFunctionWrite = withData && isIdle && latch &&
        (op == flash_ctl_pkg::OP_FUNCTION_WRITE);
    wire doQuadEntry = opOnly && isIdle && !quad_r && (op == flash_ctl_pkg::OP_QUAD_ENTRY);
    wire doQuadExit = opOnly && (isIdle || isPaused) && quad_r &&
        (op == flash_ctl_pkg::OP_QUAD_EXIT);
    wire doPause = opOnly && isRun && pausable &&
        isEither(op, flash_ctl_pkg::OP_PAUSE_A, flash_ctl_pkg::OP_PAUSE_B);
    wire doContinue = opOnly && isPaused &&
        isEither(op, flash_ctl_pkg::OP_CONTINUE_A, flash_ctl_pkg::OP_CONTINUE_B);
    wire startAny = doFullErase || doSectorErase || doBlockErase || doPageProgram ||
                    doStatusWrite;
    wire finishing = isRun && !doPause && (remain_r == flash_ctl_pkg::TIMER_LAST);
    wire busyNow = (state_r == SEQ_RUN) || (state_r == SEQ_PAUSING);
    wire loadStatus = opcodeDone && (rxShift == flash_ctl_pkg::OP_STATUS_READ);
    wire loadFunction = opcodeDone && !busyNow && (rxShift == flash_ctl_pkg::OP_FUNCTION_READ);
    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        remain_nxt = remain_r;
        settle_nxt = settle_r;
        done_nxt = 1'b0;
        unique case (state_r)
            SEQ_IDLE: begin
                if (startAny) begin
                    state_nxt = SEQ_RUN;
                    kind_nxt = doFullErase ? flash_ctl_pkg::KIND_FULL_ERASE :
                               doSectorErase ? flash_ctl_pkg::KIND_SECTOR_ERASE :
                               doBlockErase ? flash_ctl_pkg::KIND_BLOCK_ERASE :
                               doPageProgram ? flash_ctl_pkg::KIND_PAGE_PROGRAM :
                               flash_ctl_pkg::KIND_STATUS_WRITE;
                    remain_nxt = durationOf(kind_nxt);
                end
            end
            SEQ_RUN: begin
                if (doPause) begin
                    state_nxt = SEQ_PAUSING;
                    settle_nxt = 32'(PAUSE_CYC);
                end else if (finishing) begin
                    state_nxt = SEQ_IDLE;
                    kind_nxt = flash_ctl_pkg::KIND_NONE;
                    done_nxt = 1'b1;
                end else begin
                    remain_nxt = remain_r - flash_ctl_pkg::TIMER_LAST;
                end
            end
            SEQ_PAUSING: begin
                if (settle_r == flash_ctl_pkg::TIMER_LAST) begin
                    state_nxt = SEQ_PAUSED;
                end else begin
                    settle_nxt = settle_r - flash_ctl_pkg::TIMER_LAST;
                end
            end
            SEQ_PAUSED: begin
                if (doContinue) begin
                    state_nxt = SEQ_RUN;
                end
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////////
    // registers seen by the host
    always_comb begin
        status_nxt = status_r;
        function_nxt = function_r;
        status_nxt.busyFlag = (state_nxt == SEQ_RUN) || (state_nxt == SEQ_PAUSING);
        if (doLatchSet) begin
            status_nxt.writeAllowLatch = 1'b1;
        end else if (doLatchClear || finishing || doPause || doFunctionWrite) begin
            // latch clear on finish, clear command, pause or function write
            status_nxt.writeAllowLatch = 1'b0;
        end
        if (doStatusWrite) begin
            status_nxt.statusLockBit = frame_r.data[7];
            status_nxt.quadAllowBit = frame_r.data[6];
            status_nxt.protectBits = frame_r.data[5:2];
        end
        if (doFunctionWrite) begin
            function_nxt.infoRowLock = frame_r.data[7:4];
            function_nxt.topBottomSelect = frame_r.data[1];
            function_nxt.resetPinEnable = frame_r.data[0];
        end
        if (doPause) begin
            function_nxt.programPausedFlag = kindIsProgram;
            function_nxt.erasePausedFlag = !kindIsProgram;
        end else if (doContinue) begin
            function_nxt.programPausedFlag = 1'b0;
            function_nxt.erasePausedFlag = 1'b0;
        end
        quad_nxt = doQuadEntry || (quad_r && !doQuadExit);
    end
    ////////////////////////////////////////////////////////////////////////////////
    // frame shifter and read answers
    always_comb begin
        frame_nxt = frame_r;
        tx_nxt = tx_r;
        txBits_nxt = txBits_r;
        txOn_nxt = txOn_r;
        ioOut_nxt = ioOut_r;
        ioOe_nxt = ioOe_r;
        if (!frameOn) begin
            frame_nxt.bits = flash_ctl_pkg::BITS_NONE;
            frame_nxt.bytes = flash_ctl_pkg::BYTES_NONE;
            txOn_nxt = 1'b0;
            ioOe_nxt = flash_ctl_pkg::OE_NONE;
        end else if (sclkRise) begin
            frame_nxt.shift = rxShift;
            frame_nxt.bits = byteDone ? flash_ctl_pkg::BITS_NONE : rxBitsSum;
            if (opcodeDone) begin
                frame_nxt.opcode = rxShift;
            end
            if (dataDone) begin
                frame_nxt.data = rxShift;
            end
            if (byteDone && frame_r.bytes != flash_ctl_pkg::BYTES_ADDRESSED) begin
                frame_nxt.bytes = frame_r.bytes + flash_ctl_pkg::BYTES_OPCODE;
            end
            if (loadStatus || loadFunction) begin
                txOn_nxt = 1'b1;
                tx_nxt = loadStatus ? status_r : function_r;
                txBits_nxt = flash_ctl_pkg::BITS_NONE;
            end
        end else if (sclkFall && txOn_r) begin
            if (quad_r) begin
                ioOut_nxt = tx_r[7:4];
                ioOe_nxt = flash_ctl_pkg::OE_QUAD_OUT;
                tx_nxt = {tx_r[3:0], 4'h0};
            end else begin
                ioOut_nxt = {2'h0, tx_r[7], 1'h0};
                ioOe_nxt = flash_ctl_pkg::OE_SERIAL_OUT;
                tx_nxt = {tx_r[6:0], 1'b0};
            end
            txBits_nxt = txBits_r + rxStep;
            if (txBits_nxt == flash_ctl_pkg::BITS_PER_BYTE) begin
                // repeat live register while clocks continue
                txBits_nxt = flash_ctl_pkg::BITS_NONE;
                tx_nxt = (frame_r.opcode == flash_ctl_pkg::OP_STATUS_READ) ? status_r :
                                                                             function_r;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // flip-flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= SEQ_IDLE;
            kind_r <= flash_ctl_pkg::KIND_NONE;
            remain_r <= flash_ctl_pkg::TIMER_LAST;
            settle_r <= flash_ctl_pkg::TIMER_LAST;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            remain_r <= remain_nxt;
            settle_r <= settle_nxt;
            done_r <= done_nxt;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            // latch cleared, serial mode after reset
            status_r <= flash_ctl_pkg::STATUS_RESET;
            function_r <= flash_ctl_pkg::FUNCTION_RESET;
            quad_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            function_r <= function_nxt;
            quad_r <= quad_nxt;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frame_r <= flash_ctl_pkg::FRAME_RESET;
            tx_r <= 8'h00;
            txBits_r <= flash_ctl_pkg::BITS_NONE;
            txOn_r <= 1'b0;
            ioOut_r <= 4'h0;
            ioOe_r <= flash_ctl_pkg::OE_NONE;
        end else begin
            frame_r <= frame_nxt;
            tx_r <= tx_nxt;
            txBits_r <= txBits_nxt;
            txOn_r <= txOn_nxt;
            ioOut_r <= ioOut_nxt;
            ioOe_r <= ioOe_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign ioOut = ioOut_r;
    assign ioOe = ioOe_r;
    assign statusOut = status_r;
    assign functionOut = function_r;
    assign quadModeOut = quad_r;
    assign opKindOut = kind_r;
    assign opDoneOut = done_r;
endmodule : serial_flash_write_control

// [rtl/flash_ctl_pkg.sv]
package flash_ctl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // command opcodes
    localparam logic [7:0] OP_FULL_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_FULL_ERASE_B = 8'h60;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_FUNCTION_READ = 8'h48;
    localparam logic [7:0] OP_FUNCTION_WRITE = 8'h42;
    localparam logic [7:0] OP_QUAD_ENTRY = 8'h35;
    localparam logic [7:0] OP_QUAD_EXIT = 8'hf5;
    localparam logic [7:0] OP_PAUSE_A = 8'hb0;
    localparam logic [7:0] OP_PAUSE_B = 8'h75;
    localparam logic [7:0] OP_CONTINUE_A = 8'h30;
    localparam logic [7:0] OP_CONTINUE_B = 8'h7a;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE_A = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE_B = 8'hd7;
    localparam logic [7:0] OP_BLOCK_ERASE_A = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE_B = 8'hd8;

    ////////////////////////////////////////////////////////////////////////////////
    // frame counting
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] SERIAL_STEP = 4'h1;
    localparam logic [3:0] QUAD_STEP = 4'h4;
    localparam logic [3:0] BITS_NONE = 4'h0;
    localparam logic [1:0] BYTES_NONE = 2'h0;
    localparam logic [1:0] BYTES_OPCODE = 2'h1;
    localparam logic [1:0] BYTES_WITH_DATA = 2'h2;
    localparam logic [1:0] BYTES_ADDRESSED = 2'h3;
    localparam logic [3:0] OE_SERIAL_OUT = 4'h2;
    localparam logic [3:0] OE_QUAD_OUT = 4'hf;
    localparam logic [3:0] OE_NONE = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int NS_PER_US = 1000;
    localparam int PAUSE_LATENCY_US = 100;
    localparam int PAUSE_LATENCY_CYC = (PAUSE_LATENCY_US * NS_PER_US) / CLOCK_PERIOD_NS;
    localparam logic [31:0] TIMER_LAST = 32'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // register layouts and reset values
    typedef struct packed {
        logic statusLockBit;
        logic quadAllowBit;
        logic [3:0] protectBits;
        logic writeAllowLatch;
        logic busyFlag;
    } status_t;

    typedef struct packed {
        logic [3:0] infoRowLock;
        logic erasePausedFlag;
        logic programPausedFlag;
        logic topBottomSelect;
        logic resetPinEnable;
    } function_t;

    localparam status_t STATUS_RESET = 8'h00;
    localparam function_t FUNCTION_RESET = 8'h00;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] data;
        logic [7:0] shift;
        logic [1:0] bytes;
        logic [3:0] bits;
    } frame_t;

    localparam frame_t FRAME_RESET = 30'h0;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_FULL_ERASE,
        KIND_SECTOR_ERASE,
        KIND_BLOCK_ERASE,
        KIND_PAGE_PROGRAM,
        KIND_STATUS_WRITE
    } op_kind_t;

endpackage : flash_ctl_pkg

// [dv/serial_flash_write_control_chk.sv]
`timescale 1ns/1ps
module serial_flash_write_control_chk #(
    parameter int PAUSE_CYC = 20
) (
    // clock and reset
    input logic clock,
    input logic sys_rst,
    // watched ports
    input logic chipSelN,
    input logic [3:0] ioOe,
    input flash_ctl_pkg::status_t statusOut,
    input flash_ctl_pkg::function_t functionOut,
    input logic quadModeOut,
    input flash_ctl_pkg::op_kind_t opKindOut,
    input logic opDoneOut
);
    localparam int SETTLE_MAX = PAUSE_CYC + 6;
    wire pausedAny = functionOut.erasePausedFlag | functionOut.programPausedFlag;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_clears_state: assert property (disable iff (1'b0) sys_rst |=>
        statusOut == 8'h00 && !quadModeOut && ioOe == 4'h0) else $error("reset state wrong");
    a_start_needs_latch: assert property ($rose(statusOut.busyFlag) &&
        $past(opKindOut, 2) == flash_ctl_pkg::KIND_NONE |-> $past(statusOut.writeAllowLatch))
        else $error("operation started without latch");
    a_done_clears_latch: assert property (opDoneOut |-> ##[0:1] (!statusOut.busyFlag &&
        !statusOut.writeAllowLatch)) else $error("done left latch or busy");
    a_paused_no_latch: assert property (pausedAny && $past(pausedAny) |->
        !statusOut.writeAllowLatch) else $error("latch set while paused");
    a_erase_pause_kind: assert property ($rose(functionOut.erasePausedFlag) |-> opKindOut
        inside {flash_ctl_pkg::KIND_SECTOR_ERASE, flash_ctl_pkg::KIND_BLOCK_ERASE})
        else $error("erase pause on wrong kind");
    a_pause_settles: assert property ($rose(pausedAny) |-> ##[1:SETTLE_MAX]
        !statusOut.busyFlag) else $error("pause did not settle");
    a_drive_width: assert property (ioOe != 4'h0 |->
        ioOe == (quadModeOut ? 4'hf : 4'h2)) else $error("output enable width wrong");
    a_idle_released: assert property (chipSelN [*8] |-> ioOe == 4'h0)
        else $error("pins driven while deselected");
    cover property (opDoneOut);
    cover property ($rose(functionOut.erasePausedFlag));
    cover property ($rose(functionOut.programPausedFlag));
    cover property ($rose(quadModeOut));
endmodule : serial_flash_write_control_chk
bind serial_flash_write_control serial_flash_write_control_chk #(.PAUSE_CYC(PAUSE_CYC)) chk_u (
    .clock(clock), .sys_rst(sys_rst), .chipSelN(chipSelN), .ioOe(ioOe),
    .statusOut(statusOut), .functionOut(functionOut), .quadModeOut(quadModeOut),
    .opKindOut(opKindOut), .opDoneOut(opDoneOut));

// [dv/flash_host_model.sv]
`timescale 1ns/1ps
module flash_host_model (
    // clock
    input logic clock,
    // flash pins
    output logic chipSelN,
    output logic serialClock,
    output logic [3:0] ioIn,
    input logic [3:0] ioOut,
    input logic [3:0] ioOe,
    // last byte read back
    output logic [7:0] rdByte
);
    initial begin
        chipSelN = 1'b1;
        serialClock = 1'b0;
        ioIn = 4'h5;
        rdByte = 8'h00;
    end
    task automatic half;
        repeat (20) @(negedge clock);
    endtask : half
    ////////////////////////////////////////////////////////////////////////////////
    // msb first, upper nibble first, whole frame under chip select
    task automatic frame(input logic [23:0] bits, input int nBytes, input logic q);
        for (int i = 0; i < nBytes * 8; i += (q ? 4 : 1)) begin
            chipSelN = 1'b0;
            ioIn = q ? bits[23 - i -: 4] : {~ioIn[3:1], bits[23 - i]};
            half();
            // released pins read back inverted
            rdByte = q ? {rdByte[3:0], ioOut ^ ~ioOe} : {rdByte[6:0], ioOut[1] ^ ~ioOe[1]};
            serialClock = 1'b1;
            half();
            serialClock = 1'b0;
        end
        half();
        chipSelN = 1'b1;
        ioIn = ~ioIn;
        repeat (8) @(negedge clock);
    endtask : frame
endmodule : flash_host_model

// [dv/serial_flash_write_control_tb_top.sv]
`timescale 1ns/1ps
module serial_flash_write_control_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic chipSelN, serialClock, quadModeOut, opDoneOut;
    logic [3:0] ioIn, ioOut, ioOe;
    logic [7:0] rdByte, st, fn, op;
    flash_ctl_pkg::status_t statusOut;
    flash_ctl_pkg::function_t functionOut;
    flash_ctl_pkg::op_kind_t opKindOut;
    logic [7:0] expQ[$];
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'h383f;
    int cycles = 0;
    event rdDone;
    always #2 clock = ~clock;
    serial_flash_write_control #(.PAUSE_CYC(20), .FULL_ERASE_CYC(3000),
        .SECTOR_ERASE_CYC(3000), .PAGE_PROGRAM_CYC(3000),
        .STATUS_WRITE_CYC(200)) dut_u (.clock(clock), .sys_rst(sys_rst), .chipSelN(chipSelN),
        .serialClock(serialClock), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
        .statusOut(statusOut), .functionOut(functionOut), .quadModeOut(quadModeOut),
        .opKindOut(opKindOut), .opDoneOut(opDoneOut));
    flash_host_model host_u (.clock(clock), .chipSelN(chipSelN), .serialClock(serialClock),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .rdByte(rdByte));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic check_read(input logic [7:0] seen);
        logic [7:0] exp;
        exp = expQ.pop_front();
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch read byte expected %h seen %h", exp, seen);
        end
    endtask : check_read
    task automatic cmd(input logic [7:0] c, input logic q);
        host_u.frame({c, 16'h0}, 1, q);
    endtask : cmd
    task automatic rd(input logic [7:0] c, input logic [7:0] exp, input logic q);
        expQ.push_back(exp);
        host_u.frame({c, 16'h0}, 2, q);
        -> rdDone;
    endtask : rd
    task automatic wait_done;
        @(posedge clock iff opDoneOut === 1'b1);
        @(negedge clock);
    endtask : wait_done
    always @(rdDone) check_read(rdByte);
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        rd(8'h05, 8'h00, 1'b0);
        cmd(8'h06, 1'b0);
        rd(8'h05, 8'h02, 1'b0);
        cmd(8'h04, 1'b0);
        rd(8'h05, 8'h00, 1'b0);
        for (int k = 0; k < 2; k++) begin
            op = k ? 8'h60 : 8'hc7;
            cmd(op, 1'b0);
            rd(8'h05, 8'h00, 1'b0);
            cmd(8'h06, 1'b0);
            host_u.frame({op, 16'h0}, 2, 1'b0);
            rd(8'h05, 8'h02, 1'b0);
            cmd(op, 1'b0);
            rd(8'h05, 8'h03, 1'b0);
            cmd(8'h04, 1'b0);
            rd(8'h05, 8'h03, 1'b0);
            wait_done();
            rd(8'h05, 8'h00, 1'b0);
        end
        st = 8'($random(seed));
        fn = 8'($random(seed));
        cmd(8'h06, 1'b0);
        host_u.frame({8'h01, st, 8'h0}, 2, 1'b0);
        wait_done();
        st[1:0] = 2'h0;
        rd(8'h05, st, 1'b0);
        cmd(8'h06, 1'b0);
        host_u.frame({8'h42, fn, 8'h0}, 2, 1'b0);
        fn[3:2] = 2'h0;
        rd(8'h48, fn, 1'b0);
        for (int k = 0; k < 2; k++) begin
            op = k ? 8'h02 : 8'h20;
            cmd(8'h06, 1'b0);
            host_u.frame({op, 16'h0}, 3, 1'b0);
            cmd(8'hb0, 1'b0);
            repeat (40) @(negedge clock);
            rd(8'h48, fn | (k ? 8'h04 : 8'h08), 1'b0);
            cmd(8'h06, 1'b0);
            rd(8'h05, st, 1'b0);
            cmd(8'h30, 1'b0);
            rd(8'h05, st | 8'h01, 1'b0);
            wait_done();
            rd(8'h48, fn, 1'b0);
        end
        cmd(8'h35, 1'b0);
        cmd(8'h06, 1'b1);
        rd(8'h05, st | 8'h02, 1'b1);
        cmd(8'hf5, 1'b1);
        rd(8'h05, st | 8'h02, 1'b0);
        conclude();
    end
endmodule : serial_flash_write_control_tb_top
